// *** src/cpu_regs_pkg.sv ***
package cpu_regs_pkg;
  localparam int DATA_W = 32;
  localparam int SUM_W = 64;
  localparam int NUM_GPR = 16;
  localparam int GPR_IDX_W = 4;
  localparam int VEC_IDX_W = 8;
  localparam int VEC_SHIFT = 2;
  localparam int STACK_SEL_BIT = 17;
  localparam logic [31:0] PC_RST = 32'h0000_0000;
  localparam logic [31:0] WORD_RST = 32'h0000_0000;
  localparam logic [63:0] SUM_RST = 64'h0000_0000_0000_0000;

  typedef enum logic [2:0] {
    CTL_IRQ_SP, CTL_TASK_SP, CTL_VEC_BASE, CTL_STATUS,
    CTL_SAVED_PC, CTL_SAVED_FLAGS, CTL_FAST_VEC
  } ctl_sel_t;

  typedef enum logic [2:0] {
    SUM_NONE, SUM_WR_HIGH, SUM_WR_LOW, SUM_PROD_S_WIDE,
    SUM_PROD_U_WIDE, SUM_PROD_NARROW, SUM_MAC
  } sum_op_t;

  typedef struct packed {
    logic en;
    ctl_sel_t sel;
    logic [31:0] data;
  } ctl_wr_t;

  typedef struct packed {
    sum_op_t op;
    logic [31:0] opa;
    logic [31:0] opb;
  } sum_req_t;
endpackage

// *** src/cpu_register_set.sv ***
`timescale 1ns/1ps
`default_nettype none
module cpu_register_set
  import cpu_regs_pkg::*;
(
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_n,
  // general register ports
  input wire logic [GPR_IDX_W-1:0] i_rd_a_idx,
  input wire logic [GPR_IDX_W-1:0] i_rd_b_idx,
  input wire logic i_gpr_wr_en,
  input wire logic [GPR_IDX_W-1:0] i_gpr_wr_idx,
  input wire logic [31:0] i_gpr_wr_data,
  output logic [31:0] o_rd_a_data,
  output logic [31:0] o_rd_b_data,
  // control register writes and status updates
  input wire ctl_wr_t i_ctl_wr,
  input wire logic i_flags_wr_en,
  input wire logic [31:0] i_flags_data,
  // program flow
  input wire logic i_pc_load,
  input wire logic [31:0] i_pc_next,
  input wire logic i_fast_take,
  input wire logic i_fast_return,
  input wire logic [VEC_IDX_W-1:0] i_vec_num,
  // accumulator
  input wire sum_req_t i_sum_req,
  // state outputs
  output logic [31:0] o_pc,
  output logic [31:0] o_status_word,
  output logic [31:0] o_irq_stack_ptr,
  output logic [31:0] o_task_stack_ptr,
  output logic [31:0] o_vector_table_base,
  output logic [31:0] o_vector_addr,
  output logic [31:0] o_saved_count_fast,
  output logic [31:0] o_saved_flags_fast,
  output logic [31:0] o_fast_vector_target,
  output logic [31:0] o_sum_high,
  output logic [31:0] o_sum_mid
);
  // ************************************************************
  // general registers and stack pointers
  // ************************************************************
  logic [31:0] gpr_r [1:NUM_GPR-1];
  logic [31:0] gpr_nxt [1:NUM_GPR-1];
  logic [31:0] irq_sp_r, irq_sp_nxt, task_sp_r, task_sp_nxt;
  logic [31:0] rd_a_r, rd_a_nxt, rd_b_r, rd_b_nxt;
  logic [31:0] status_r, status_nxt;
  logic use_task_sp;

  assign use_task_sp = status_r[STACK_SEL_BIT];

  function automatic logic [31:0] gpr_read(input logic [GPR_IDX_W-1:0] idx);
    logic [31:0] v;
    v = use_task_sp ? task_sp_r : irq_sp_r;
    if (idx != '0) begin
      v = gpr_r[idx];
    end
    return v;
  endfunction

  always_comb begin
    for (int k = 1; k < NUM_GPR; k++) begin
      gpr_nxt[k] = gpr_r[k];
    end
    irq_sp_nxt = irq_sp_r;
    task_sp_nxt = task_sp_r;
    if (i_gpr_wr_en) begin
      if (i_gpr_wr_idx != '0) begin
        gpr_nxt[i_gpr_wr_idx] = i_gpr_wr_data;
      end else if (use_task_sp) begin
        task_sp_nxt = i_gpr_wr_data;
      end else begin
        irq_sp_nxt = i_gpr_wr_data;
      end
    end
    if (i_ctl_wr.en && i_ctl_wr.sel == CTL_IRQ_SP) begin
      irq_sp_nxt = i_ctl_wr.data;
    end
    if (i_ctl_wr.en && i_ctl_wr.sel == CTL_TASK_SP) begin
      task_sp_nxt = i_ctl_wr.data;
    end
    rd_a_nxt = gpr_read(i_rd_a_idx);
    rd_b_nxt = gpr_read(i_rd_b_idx);
  end

  genvar g;
  generate
    for (g = 1; g < NUM_GPR; g++) begin : g_gpr
      always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
          gpr_r[g] <= WORD_RST;
        end else begin
          gpr_r[g] <= gpr_nxt[g];
        end
      end
    end
  endgenerate

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      irq_sp_r <= WORD_RST;
      task_sp_r <= WORD_RST;
      rd_a_r <= WORD_RST;
      rd_b_r <= WORD_RST;
    end else begin
      irq_sp_r <= irq_sp_nxt;
      task_sp_r <= task_sp_nxt;
      rd_a_r <= rd_a_nxt;
      rd_b_r <= rd_b_nxt;
    end
  end

  // ************************************************************
  // control registers and program flow
  // ************************************************************
  logic [31:0] pc_r, pc_nxt, vbase_r, vbase_nxt, vaddr_r, vaddr_nxt;
  logic [31:0] saved_pc_r, saved_pc_nxt, saved_st_r, saved_st_nxt, fvec_r, fvec_nxt;

  always_comb begin
    pc_nxt = pc_r;
    status_nxt = status_r;
    vbase_nxt = vbase_r;
    saved_pc_nxt = saved_pc_r;
    saved_st_nxt = saved_st_r;
    fvec_nxt = fvec_r;
    if (i_flags_wr_en) begin
      status_nxt = i_flags_data;
    end
    if (i_ctl_wr.en) begin
      case (i_ctl_wr.sel)
        CTL_VEC_BASE: vbase_nxt = i_ctl_wr.data;
        CTL_STATUS: status_nxt = i_ctl_wr.data;
        CTL_SAVED_PC: saved_pc_nxt = i_ctl_wr.data;
        CTL_SAVED_FLAGS: saved_st_nxt = i_ctl_wr.data;
        CTL_FAST_VEC: fvec_nxt = i_ctl_wr.data;
        default: ;
      endcase
    end
    if (i_pc_load) begin
      pc_nxt = i_pc_next;
    end
    // fast entry outranks return, both outrank plain writes
    if (i_fast_take) begin
      saved_pc_nxt = pc_r;
      saved_st_nxt = status_r;
      pc_nxt = fvec_r;
    end else if (i_fast_return) begin
      pc_nxt = saved_pc_r;
      status_nxt = saved_st_r;
    end
    vaddr_nxt = vbase_r + {{(32-VEC_IDX_W-VEC_SHIFT){1'b0}}, i_vec_num, {VEC_SHIFT{1'b0}}};
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pc_r <= PC_RST;
      status_r <= WORD_RST;
      vbase_r <= WORD_RST;
      vaddr_r <= WORD_RST;
      saved_pc_r <= WORD_RST;
      saved_st_r <= WORD_RST;
      fvec_r <= WORD_RST;
    end else begin
      pc_r <= pc_nxt;
      status_r <= status_nxt;
      vbase_r <= vbase_nxt;
      vaddr_r <= vaddr_nxt;
      saved_pc_r <= saved_pc_nxt;
      saved_st_r <= saved_st_nxt;
      fvec_r <= fvec_nxt;
    end
  end

  // ************************************************************
  // accumulator
  // ************************************************************
  logic [63:0] sum_r, sum_nxt;
  logic signed [63:0] sa, sb, prod_s;
  logic [63:0] prod_u;

  always_comb begin
    sa = {{32{i_sum_req.opa[31]}}, i_sum_req.opa};
    sb = {{32{i_sum_req.opb[31]}}, i_sum_req.opb};
    prod_s = sa * sb;
    prod_u = {32'h0000_0000, i_sum_req.opa} * {32'h0000_0000, i_sum_req.opb};
    sum_nxt = sum_r;
    case (i_sum_req.op)
      SUM_WR_HIGH: sum_nxt = {i_sum_req.opa, sum_r[31:0]};
      SUM_WR_LOW: sum_nxt = {sum_r[63:32], i_sum_req.opa};
      SUM_PROD_S_WIDE: sum_nxt = prod_s;
      SUM_PROD_U_WIDE: sum_nxt = prod_u;
      SUM_PROD_NARROW: sum_nxt = {{32{prod_s[31]}}, prod_s[31:0]};
      SUM_MAC: sum_nxt = sum_r + prod_s;
      default: sum_nxt = sum_r;
    endcase
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sum_r <= SUM_RST;
    end else begin
      sum_r <= sum_nxt;
    end
  end

  assign o_rd_a_data = rd_a_r;
  assign o_rd_b_data = rd_b_r;
  assign o_pc = pc_r;
  assign o_status_word = status_r;
  assign o_irq_stack_ptr = irq_sp_r;
  assign o_task_stack_ptr = task_sp_r;
  assign o_vector_table_base = vbase_r;
  assign o_vector_addr = vaddr_r;
  assign o_saved_count_fast = saved_pc_r;
  assign o_saved_flags_fast = saved_st_r;
  assign o_fast_vector_target = fvec_r;
  assign o_sum_high = sum_r[63:32];
  assign o_sum_mid = sum_r[47:16];

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);

  property p_gpr_rw;
    (i_gpr_wr_en && i_gpr_wr_idx != '0 && i_rd_a_idx == i_gpr_wr_idx) ##1
      (!i_gpr_wr_en && i_rd_a_idx == $past(i_rd_a_idx)) |=> o_rd_a_data == $past(i_gpr_wr_data, 2);
  endproperty
  a_gpr_rw: assert property (p_gpr_rw) else $error("general register readback wrong");
  property p_stack_sel;
    (i_gpr_wr_en && i_gpr_wr_idx == '0 && use_task_sp && !i_ctl_wr.en)
      |=> o_task_stack_ptr == $past(i_gpr_wr_data) && $stable(o_irq_stack_ptr);
  endproperty
  a_stack_sel: assert property (p_stack_sel) else $error("stack pointer select wrong");
  property p_vec;
    ##1 o_vector_addr == $past(o_vector_table_base) + ({24'h000000, $past(i_vec_num)} << 2);
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
  property p_pc_load;
    (i_pc_load && !i_fast_take && !i_fast_return) |=> o_pc == $past(i_pc_next);
  endproperty
  a_pc_load: assert property (p_pc_load) else $error("program counter load wrong");
  property p_fast_take;
    i_fast_take |=> o_saved_count_fast == $past(o_pc) && o_saved_flags_fast == $past(o_status_word);
  endproperty
  a_fast_take: assert property (p_fast_take) else $error("fast entry save wrong");
  property p_fast_branch;
    i_fast_take |=> o_pc == $past(o_fast_vector_target);
  endproperty
  a_fast_branch: assert property (p_fast_branch) else $error("fast branch wrong");
  property p_fast_ret;
    (i_fast_return && !i_fast_take) |=> o_pc == $past(o_saved_count_fast) &&
      o_status_word == $past(o_saved_flags_fast);
  endproperty
  a_fast_ret: assert property (p_fast_ret) else $error("fast return restore wrong");
  property p_flags;
    (i_flags_wr_en && !i_ctl_wr.en && !i_fast_return) |=> o_status_word == $past(i_flags_data);
  endproperty
  a_flags: assert property (p_flags) else $error("status update wrong");
  property p_sum_halves;
    (i_sum_req.op == SUM_WR_HIGH) ##1 (i_sum_req.op == SUM_WR_LOW)
      |=> o_sum_high == $past(i_sum_req.opa, 2) &&
      o_sum_mid == {$past(i_sum_req.opa[15:0], 2), $past(i_sum_req.opa[31:16])};
  endproperty
  a_sum_halves: assert property (p_sum_halves) else $error("sum half writes wrong");
  property p_mac;
    (i_sum_req.op == SUM_MAC) |=> sum_r == $past(sum_r) + $past(prod_s);
  endproperty
  a_mac: assert property (p_mac) else $error("accumulate result wrong");

  c_fast_take: cover property (i_fast_take ##1 i_fast_return);
  c_mac: cover property (i_sum_req.op == SUM_MAC ##1 i_sum_req.op == SUM_MAC);
  c_halves: cover property (i_sum_req.op == SUM_WR_HIGH ##1 i_sum_req.op == SUM_WR_LOW);
  c_task_sp: cover property (i_gpr_wr_en && i_gpr_wr_idx == '0 && use_task_sp);
endmodule
`default_nettype wire

// *** verif/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
  import cpu_regs_pkg::*;
  typedef struct {int id; logic [31:0] v;} note_t;
  // ****************************************
  // signals
  // ****************************************
  logic i_core_clk = 1'b0;
  logic i_rst_n = 1'b0;
  logic [3:0] i_rd_a_idx = 4'h0;
  logic [3:0] i_rd_b_idx = 4'h0;
  logic i_gpr_wr_en = 1'b0;
  logic [3:0] i_gpr_wr_idx = 4'h0;
  logic [31:0] i_gpr_wr_data = 32'h0;
  ctl_wr_t i_ctl_wr = '0;
  logic i_flags_wr_en = 1'b0;
  logic [31:0] i_flags_data = 32'h0;
  logic i_pc_load = 1'b0;
  logic [31:0] i_pc_next = 32'h0;
  logic i_fast_take = 1'b0;
  logic i_fast_return = 1'b0;
  logic [7:0] i_vec_num = 8'h0;
  sum_req_t i_sum_req = '0;
  logic [31:0] o_rd_a_data, o_rd_b_data, o_pc, o_status_word, o_irq_stack_ptr;
  logic [31:0] o_task_stack_ptr, o_vector_table_base, o_vector_addr, o_saved_count_fast;
  logic [31:0] o_saved_flags_fast, o_fast_vector_target, o_sum_high, o_sum_mid;
  logic [31:0] obs [13];
  string nm [13] = '{"pc", "status", "irq_sp", "task_sp", "vec_base", "vec_addr",
    "saved_pc", "saved_flags", "fast_vec", "sum_high", "sum_mid", "rd_a", "rd_b"};
  note_t q[$];
  note_t cur;
  int n_mismatch = 0;
  int n_tests = 0;
  int seed = 53294;
  logic [31:0] mem [16];
  logic [31:0] a, b, h, l;
  logic [63:0] sum_v, ps;
  cpu_register_set i_dut (.i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_rd_a_idx(i_rd_a_idx),
    .i_rd_b_idx(i_rd_b_idx), .i_gpr_wr_en(i_gpr_wr_en), .i_gpr_wr_idx(i_gpr_wr_idx),
    .i_gpr_wr_data(i_gpr_wr_data), .o_rd_a_data(o_rd_a_data), .o_rd_b_data(o_rd_b_data),
    .i_ctl_wr(i_ctl_wr), .i_flags_wr_en(i_flags_wr_en), .i_flags_data(i_flags_data),
    .i_pc_load(i_pc_load), .i_pc_next(i_pc_next), .i_fast_take(i_fast_take),
    .i_fast_return(i_fast_return), .i_vec_num(i_vec_num), .i_sum_req(i_sum_req), .o_pc(o_pc),
    .o_status_word(o_status_word), .o_irq_stack_ptr(o_irq_stack_ptr),
    .o_task_stack_ptr(o_task_stack_ptr), .o_vector_table_base(o_vector_table_base),
    .o_vector_addr(o_vector_addr), .o_saved_count_fast(o_saved_count_fast),
    .o_saved_flags_fast(o_saved_flags_fast), .o_fast_vector_target(o_fast_vector_target),
    .o_sum_high(o_sum_high), .o_sum_mid(o_sum_mid));
  always_comb obs = '{o_pc, o_status_word, o_irq_stack_ptr, o_task_stack_ptr,
    o_vector_table_base, o_vector_addr, o_saved_count_fast, o_saved_flags_fast,
    o_fast_vector_target, o_sum_high, o_sum_mid, o_rd_a_data, o_rd_b_data};
  initial begin
    forever #12.5 i_core_clk = ~i_core_clk;
  end
  // ****************************************
  // driver tasks
  // ****************************************
  task automatic note(input int id, input logic [31:0] v);
    q.push_back('{id, v});
  endtask
  task automatic fin();
    @(posedge i_core_clk);
    i_gpr_wr_en <= 1'b0;
    i_ctl_wr.en <= 1'b0;
    i_flags_wr_en <= 1'b0;
    i_pc_load <= 1'b0;
    i_fast_take <= 1'b0;
    i_fast_return <= 1'b0;
    i_sum_req.op <= SUM_NONE;
  endtask
  task automatic ctl(input ctl_sel_t s, input logic [31:0] d);
    @(posedge i_core_clk);
    i_ctl_wr <= '{en: 1'b1, sel: s, data: d};
    fin();
  endtask
  task automatic flags(input logic [31:0] d);
    @(posedge i_core_clk);
    i_flags_wr_en <= 1'b1;
    i_flags_data <= d;
    fin();
    note(1, d);
  endtask
  task automatic rd(input int ka, input int kb);
    @(posedge i_core_clk);
    i_rd_a_idx <= 4'(ka);
    i_rd_b_idx <= 4'(kb);
    fin();
  endtask
  task automatic accop(input sum_op_t op, input logic [31:0] x, input logic [31:0] y);
    @(posedge i_core_clk);
    i_sum_req <= '{op: op, opa: x, opb: y};
    fin();
  endtask
  task automatic pcload(input logic [31:0] p);
    @(posedge i_core_clk);
    i_pc_load <= 1'b1;
    i_pc_next <= p;
    fin();
    note(0, p);
  endtask
  // ****************************************
  // monitor
  // ****************************************
  always @(negedge i_core_clk) begin
    while (q.size() > 0) begin
      cur = q.pop_front();
      n_tests++;
      if (obs[cur.id] !== cur.v) begin
        n_mismatch++;
        $display("Error %s expected %h seen %h", nm[cur.id], cur.v, obs[cur.id]);
      end
    end
  end
  task automatic report_and_stop();
    $display("mismatches %0d, checks %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  initial begin
    #50000;
    n_mismatch++;
    report_and_stop();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (2) @(posedge i_core_clk);
    i_rst_n <= 1'b1;
    for (int k = 0; k < 11; k++) note(k, 32'h0);
    for (int k = 1; k < 16; k++) begin
      @(posedge i_core_clk);
      mem[k] = $random(seed);
      i_gpr_wr_en <= 1'b1;
      i_gpr_wr_idx <= 4'(k);
      i_gpr_wr_data <= mem[k];
      i_rd_a_idx <= 4'(k);
      fin();
    end
    for (int k = 1; k < 16; k++) begin
      rd(k, 16 - k);
      note(11, mem[k]);
      note(12, mem[16 - k]);
    end
    ctl(CTL_IRQ_SP, 32'h0000_1000);
    ctl(CTL_TASK_SP, 32'h0000_2000);
    note(2, 32'h0000_1000);
    rd(0, 0);
    note(11, 32'h0000_1000);
    flags(32'h0002_0000);
    rd(0, 5);
    note(11, 32'h0000_2000);
    @(posedge i_core_clk);
    i_gpr_wr_en <= 1'b1;
    i_gpr_wr_idx <= 4'h0;
    i_gpr_wr_data <= 32'h0000_3000;
    fin();
    note(3, 32'h0000_3000);
    note(2, 32'h0000_1000);
    ctl(CTL_VEC_BASE, 32'h0001_0000);
    note(4, 32'h0001_0000);
    foreach (mem[v]) begin
      @(posedge i_core_clk);
      i_vec_num <= 8'(v * 17);
      fin();
      note(5, 32'h0001_0000 + 32'(v * 17 * 4));
    end
    ctl(CTL_FAST_VEC, 32'h0000_8000);
    note(8, 32'h0000_8000);
    flags(32'h0000_00C5);
    pcload(32'h0000_0400);
    @(posedge i_core_clk);
    i_fast_take <= 1'b1;
    fin();
    note(0, 32'h0000_8000);
    note(6, 32'h0000_0400);
    note(7, 32'h0000_00C5);
    note(1, 32'h0000_00C5);
    flags(32'h0002_0001);
    pcload(32'h0000_8010);
    @(posedge i_core_clk);
    i_fast_return <= 1'b1;
    fin();
    note(0, 32'h0000_0400);
    note(1, 32'h0000_00C5);
    h = $random(seed);
    l = $random(seed);
    accop(SUM_WR_HIGH, h, 32'h0);
    note(9, h);
    accop(SUM_WR_LOW, l, 32'h0);
    note(10, {h[15:0], l[31:16]});
    h = $random(seed);
    accop(SUM_WR_HIGH, h, 32'h0);
    note(9, h);
    note(10, {h[15:0], l[31:16]});
    sum_v = {h, l};
    for (int i = 0; i < 8; i++) begin
      a = $random(seed);
      b = $random(seed);
      ps = {{32{a[31]}}, a} * {{32{b[31]}}, b};
      case (i % 4)
        0: sum_v = ps;
        1: sum_v = {32'h0, a} * {32'h0, b};
        2: sum_v = {{32{ps[31]}}, ps[31:0]};
        default: sum_v = sum_v + ps;
      endcase
      accop(sum_op_t'(3 + i % 4), a, b);
      note(9, sum_v[63:32]);
      note(10, sum_v[47:16]);
    end
    // let the monitor drain the last notes first
    repeat (2) @(posedge i_core_clk);
    report_and_stop();
  end
endmodule
`default_nettype wire
